// ===== hw/aisel_pkg.sv
package aisel_pkg;
	// ------------------------------------------------------------
	// Register offsets on the special-function bus
	// ------------------------------------------------------------
	localparam logic [7:0] CONVERTER_INPUT_SELECT_ADDR = 8'h00_BB;
	localparam logic [7:0] REFERENCE_CONTROL_ADDR = 8'h00_D1;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [5:0] POSITIVE_INPUT_RESET = 6'h00_3F;
	localparam logic [3:0] REFERENCE_CONTROL_RESET = 4'h0_0;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int POSITIVE_INPUT_FIELD_MSB = 5;
	localparam int REF_BUFFER_BIT = 0;
	localparam int BIAS_BIT = 1;
	localparam int SENSOR_BIT = 2;
	localparam int SOURCE_BIT = 3;

	// ------------------------------------------------------------
	// Select codes
	// ------------------------------------------------------------
	localparam logic [5:0] CODE_LAST_PORT = 6'h00_1F;
	localparam logic [5:0] CODE_LARGE_PKG_FIRST = 6'h00_19;
	localparam logic [5:0] CODE_RESERVED_FIRST = 6'h00_20;
	localparam logic [5:0] CODE_RESERVED_LAST = 6'h00_2F;
	localparam logic [5:0] CODE_THERMAL = 6'h00_30;
	localparam logic [5:0] CODE_SUPPLY = 6'h00_31;
	localparam logic [5:0] CODE_GROUND = 6'h00_3F;

	typedef enum logic [2:0] {
		AISEL_SRC_NONE = 3'b000,
		AISEL_SRC_PORT = 3'b001,
		AISEL_SRC_THERMAL = 3'b010,
		AISEL_SRC_SUPPLY = 3'b011,
		AISEL_SRC_GROUND = 3'b100
	} aisel_src_e;

	// Bus access from the processor
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} aisel_bus_s;

	// Analog control lines
	typedef struct packed {
		aisel_src_e src;
		logic [31:0] port_sel;
		logic thermal_on;
		logic bias_on;
		logic ref_buffer_on;
		logic ref_from_supply;
	} aisel_ana_s;

	typedef struct packed {
		logic [5:0] positive_input_code;
		logic reference_source_select;
		logic thermal_sensor_on;
		logic bias_generator_on;
		logic reference_buffer_on;
		logic [7:0] rdata;
		aisel_ana_s ana;
	} aisel_state_s;
endpackage

// ===== hw/aisel_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Select register upper two bits read zero
// - Six-bit field chooses converter positive input
// - Codes 011001-011111 route port three pins on the larger package only; smaller package selects none
// - Disabled sensor output floats; readings meaningless
// - Sensor enable zero off, one on
// - Source select zero pin, one supply
// - Bias automatically on when users enabled
// - Bias enable one forces generator on
// - Buffer enable drives reference onto pin
// - Reference control bit layout, reset zero
module aisel_top (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// Special-function bus
	input wire aisel_pkg::aisel_bus_s i_bus,
	output logic [7:0] o_rdata,
	// Peripherals asking for bias
	input wire logic i_converter_zero_on,
	input wire logic i_oscillator_on,
	// Larger package strap
	input wire logic i_large_package,
	// Analog controls
	output aisel_pkg::aisel_ana_s o_ana
);
	aisel_pkg::aisel_state_s st, next_st;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		if (i_bus.wr) begin
			if (i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR) begin
				next_st.positive_input_code = i_bus.wdata[aisel_pkg::POSITIVE_INPUT_FIELD_MSB:0];
			end
			if (i_bus.addr == aisel_pkg::REFERENCE_CONTROL_ADDR) begin
				next_st.reference_buffer_on = i_bus.wdata[aisel_pkg::REF_BUFFER_BIT];
				next_st.bias_generator_on = i_bus.wdata[aisel_pkg::BIAS_BIT];
				next_st.thermal_sensor_on = i_bus.wdata[aisel_pkg::SENSOR_BIT];
				next_st.reference_source_select = i_bus.wdata[aisel_pkg::SOURCE_BIT];
			end
		end

		// ------------------------------------------------------------
		// Read data
		// ------------------------------------------------------------
		// Read data registered; unmapped addresses read zero
		next_st.rdata = 8'h00_00;
		if (i_bus.rd) begin
			case (i_bus.addr)
				aisel_pkg::CONVERTER_INPUT_SELECT_ADDR: begin
					next_st.rdata = {2'b00, next_st.positive_input_code};
				end
				aisel_pkg::REFERENCE_CONTROL_ADDR: begin
					next_st.rdata = {4'h0, next_st.reference_source_select, next_st.thermal_sensor_on,
						next_st.bias_generator_on, next_st.reference_buffer_on};
				end
				default: begin
					next_st.rdata = 8'h00_00;
				end
			endcase
		end

		// ------------------------------------------------------------
		// Input multiplexer decode
		// ------------------------------------------------------------
		// Decode from the value being stored so outputs track the register
		next_st.ana.port_sel = '0;
		next_st.ana.src = aisel_pkg::AISEL_SRC_NONE;
		if (next_st.positive_input_code <= aisel_pkg::CODE_LAST_PORT) begin
			// Port three upper pins only bonded out on the larger package
			if (next_st.positive_input_code < aisel_pkg::CODE_LARGE_PKG_FIRST || i_large_package) begin
				next_st.ana.src = aisel_pkg::AISEL_SRC_PORT;
				next_st.ana.port_sel[next_st.positive_input_code[4:0]] = 1'b1;
			end
		end else if (next_st.positive_input_code == aisel_pkg::CODE_THERMAL) begin
			next_st.ana.src = aisel_pkg::AISEL_SRC_THERMAL;
		end else if (next_st.positive_input_code == aisel_pkg::CODE_SUPPLY) begin
			next_st.ana.src = aisel_pkg::AISEL_SRC_SUPPLY;
		end else if (next_st.positive_input_code == aisel_pkg::CODE_GROUND) begin
			next_st.ana.src = aisel_pkg::AISEL_SRC_GROUND;
		end

		// ------------------------------------------------------------
		// Reference and bias controls
		// ------------------------------------------------------------
		// Sensor off leaves its output floating in the analog cell
		next_st.ana.thermal_on = next_st.thermal_sensor_on;
		next_st.ana.ref_from_supply = next_st.reference_source_select;
		next_st.ana.ref_buffer_on = next_st.reference_buffer_on;
		next_st.ana.bias_on = next_st.bias_generator_on | next_st.thermal_sensor_on
			| i_converter_zero_on | i_oscillator_on;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= '0;
			st.positive_input_code <= aisel_pkg::POSITIVE_INPUT_RESET;
			{st.reference_source_select, st.thermal_sensor_on,
				st.bias_generator_on, st.reference_buffer_on} <= aisel_pkg::REFERENCE_CONTROL_RESET;
			st.ana.src <= aisel_pkg::AISEL_SRC_GROUND;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_ana = st.ana;

	// ------------------------------------------------------------
	// Checks on the select register
	// ------------------------------------------------------------
	a_upper_bits_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.rd && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR
		|=> o_rdata[7:6] == 2'b00)
		else $error("select upper bits not zero");
	a_select_stored: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR
		|=> st.positive_input_code == $past(i_bus.wdata[aisel_pkg::POSITIVE_INPUT_FIELD_MSB:0]))
		else $error("select code not stored");
	a_select_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.rd && !i_bus.wr && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR
		|=> o_rdata == {2'b00, $past(st.positive_input_code)})
		else $error("select read back wrong");
	a_write_selects_port: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR
		&& i_bus.wdata[5:0] < aisel_pkg::CODE_LARGE_PKG_FIRST
		|=> o_ana.src == aisel_pkg::AISEL_SRC_PORT && o_ana.port_sel[$past(i_bus.wdata[4:0])])
		else $error("port not selected");
	a_port_one_hot: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_ana.src == aisel_pkg::AISEL_SRC_PORT
		|-> $onehot(o_ana.port_sel))
		else $error("port select not one-hot");
	a_no_port_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_ana.src != aisel_pkg::AISEL_SRC_PORT
		|-> o_ana.port_sel == '0)
		else $error("port select set without port source");
	a_small_pkg_block: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		!i_large_package && $stable(i_large_package)
		&& st.positive_input_code >= aisel_pkg::CODE_LARGE_PKG_FIRST
		&& st.positive_input_code <= aisel_pkg::CODE_LAST_PORT
		|-> o_ana.src == aisel_pkg::AISEL_SRC_NONE)
		else $error("missing pin selected");
	a_large_pkg_route: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR && i_large_package
		&& i_bus.wdata[5:0] >= aisel_pkg::CODE_LARGE_PKG_FIRST
		&& i_bus.wdata[5:0] <= aisel_pkg::CODE_LAST_PORT
		|=> o_ana.src == aisel_pkg::AISEL_SRC_PORT && o_ana.port_sel[$past(i_bus.wdata[4:0])])
		else $error("large package pin not routed");
	a_special_codes: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR
		&& i_bus.wdata[5:0] == aisel_pkg::CODE_THERMAL
		|=> o_ana.src == aisel_pkg::AISEL_SRC_THERMAL)
		else $error("sensor code not decoded");
	a_supply_code: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR
		&& i_bus.wdata[5:0] == aisel_pkg::CODE_SUPPLY
		|=> o_ana.src == aisel_pkg::AISEL_SRC_SUPPLY)
		else $error("supply code not decoded");
	a_ground_code: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR
		&& i_bus.wdata[5:0] == aisel_pkg::CODE_GROUND
		|=> o_ana.src == aisel_pkg::AISEL_SRC_GROUND)
		else $error("ground code not decoded");
	a_reserved_codes: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::CONVERTER_INPUT_SELECT_ADDR
		&& i_bus.wdata[5:0] >= aisel_pkg::CODE_RESERVED_FIRST
		&& i_bus.wdata[5:0] <= aisel_pkg::CODE_RESERVED_LAST
		|=> o_ana.src == aisel_pkg::AISEL_SRC_NONE)
		else $error("reserved code routed");

	// ------------------------------------------------------------
	// Checks on the reference control register
	// ------------------------------------------------------------
	a_sensor_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::REFERENCE_CONTROL_ADDR
		|=> o_ana.thermal_on == $past(i_bus.wdata[aisel_pkg::SENSOR_BIT]))
		else $error("sensor enable wrong");
	a_source_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::REFERENCE_CONTROL_ADDR
		|=> o_ana.ref_from_supply == $past(i_bus.wdata[aisel_pkg::SOURCE_BIT]))
		else $error("source select wrong");
	a_buffer_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::REFERENCE_CONTROL_ADDR
		|=> o_ana.ref_buffer_on == $past(i_bus.wdata[aisel_pkg::REF_BUFFER_BIT]))
		else $error("buffer enable wrong");
	a_ref_readback: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.rd && !i_bus.wr && i_bus.addr == aisel_pkg::REFERENCE_CONTROL_ADDR
		|=> o_rdata == {4'h0, $past(st.reference_source_select), $past(st.thermal_sensor_on),
			$past(st.bias_generator_on), $past(st.reference_buffer_on)})
		else $error("reference control read back wrong");

	// ------------------------------------------------------------
	// Checks on the bias generator
	// ------------------------------------------------------------
	a_bias_auto: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_converter_zero_on || i_oscillator_on
		|=> o_ana.bias_on)
		else $error("bias not automatic");
	a_bias_sensor: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::REFERENCE_CONTROL_ADDR && i_bus.wdata[aisel_pkg::SENSOR_BIT]
		|=> o_ana.bias_on)
		else $error("sensor did not request bias");
	a_bias_forced: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::REFERENCE_CONTROL_ADDR && i_bus.wdata[aisel_pkg::BIAS_BIT]
		|=> o_ana.bias_on)
		else $error("bias not forced");
	a_bias_idle_off: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_bus.wr && i_bus.addr == aisel_pkg::REFERENCE_CONTROL_ADDR && !i_converter_zero_on && !i_oscillator_on
		&& !i_bus.wdata[aisel_pkg::BIAS_BIT] && !i_bus.wdata[aisel_pkg::SENSOR_BIT]
		|=> !o_ana.bias_on)
		else $error("bias on with no request");

	// ------------------------------------------------------------
	// Coverage
	// ------------------------------------------------------------
	c_select_thermal: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_ana.src == aisel_pkg::AISEL_SRC_THERMAL && o_ana.thermal_on);
	c_select_port: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_ana.src == aisel_pkg::AISEL_SRC_PORT);
	c_bias_forced_idle: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
		st.bias_generator_on && !i_converter_zero_on && !i_oscillator_on);
	c_large_pkg_pin: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_ana.src == aisel_pkg::AISEL_SRC_PORT && o_ana.port_sel[31]);
	c_supply_reference: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
		o_ana.ref_from_supply && o_ana.ref_buffer_on);
endmodule // aisel_top

// ===== tb/aisel_ref_model.sv
`timescale 1ns/100ps
module aisel_ref_model (
	// Controls from the block
	input wire aisel_pkg::aisel_ana_s i_ana,
	// Analog state seen
	output logic o_reading_valid,
	output logic o_vref_pin_driven
);
	// Floating sensor gives no usable reading
	assign o_reading_valid = (i_ana.src != aisel_pkg::AISEL_SRC_NONE) &&
		((i_ana.src != aisel_pkg::AISEL_SRC_THERMAL) || i_ana.thermal_on);
	assign o_vref_pin_driven = i_ana.ref_buffer_on;
endmodule // aisel_ref_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin errors++; \
	$display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb_top;
	logic i_sys_clk, i_rstn, i_converter_zero_on, i_oscillator_on, i_large_package, valid, vpin;
	aisel_pkg::aisel_bus_s i_bus;
	logic [7:0] o_rdata;
	aisel_pkg::aisel_ana_s o_ana;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	aisel_top dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_bus(i_bus), .o_rdata(o_rdata),
		.i_converter_zero_on(i_converter_zero_on), .i_oscillator_on(i_oscillator_on),
		.i_large_package(i_large_package), .o_ana(o_ana));
	aisel_ref_model model (.i_ana(o_ana), .o_reading_valid(valid), .o_vref_pin_driven(vpin));
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// Far above the roughly 130 cycles the tests need
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			give_verdict();
		end
	end
	// --------------------------
	// Verdict, bus and bias request tasks
	// --------------------------
	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		i_bus.wr = 1'b1;
		i_bus.addr = a;
		i_bus.wdata = d;
		@(negedge i_sys_clk);
		i_bus.wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
		@(negedge i_sys_clk);
		i_bus.rd = 1'b1;
		i_bus.addr = a;
		@(negedge i_sys_clk);
		i_bus.rd = 1'b0;
		`CHK("rdata", ex, o_rdata)
	endtask
	task automatic sel(input logic [7:0] c, input aisel_pkg::aisel_src_e s, input logic [31:0] ps);
		wr(8'h00_BB, c);
		`CHK("src", s, o_ana.src)
		`CHK("port_sel", ps, o_ana.port_sel)
	endtask
	task automatic req(input logic cv, input logic os, input logic ex);
		@(negedge i_sys_clk);
		i_converter_zero_on = cv;
		i_oscillator_on = os;
		repeat (2) @(negedge i_sys_clk);
		`CHK("bias", ex, o_ana.bias_on)
	endtask
	// --------------------------
	// Tests
	// --------------------------
	initial begin
		i_rstn = 1'b0;
		i_bus = '0;
		i_converter_zero_on = 1'b0;
		i_oscillator_on = 1'b0;
		i_large_package = 1'b0;
		repeat (16) @(negedge i_sys_clk);
		i_rstn = 1'b1;
		rd_chk(8'h00_BB, 8'h00_3F);
		rd_chk(8'h00_D1, 8'h00_00);
		rd_chk(8'h00_42, 8'h00_00);
		`CHK("src", aisel_pkg::AISEL_SRC_GROUND, o_ana.src)
		wr(8'h00_BB, 8'h00_C5);
		rd_chk(8'h00_BB, 8'h00_05);
		for (int c = 0; c < 25; c++)
			sel(8'(c), aisel_pkg::AISEL_SRC_PORT, 32'h0000_0001 << c);
		sel(8'h00_19, aisel_pkg::AISEL_SRC_NONE, 32'h0000_0000);
		i_large_package = 1'b1;
		for (int c = 25; c < 32; c++)
			sel(8'(c), aisel_pkg::AISEL_SRC_PORT, 32'h0000_0001 << c);
		sel(8'h00_20, aisel_pkg::AISEL_SRC_NONE, 32'h0000_0000);
		sel(8'h00_2F, aisel_pkg::AISEL_SRC_NONE, 32'h0000_0000);
		sel(8'h00_31, aisel_pkg::AISEL_SRC_SUPPLY, 32'h0000_0000);
		sel(8'h00_3F, aisel_pkg::AISEL_SRC_GROUND, 32'h0000_0000);
		sel(8'h00_30, aisel_pkg::AISEL_SRC_THERMAL, 32'h0000_0000);
		`CHK("valid", 1'b0, valid)
		wr(8'h00_D1, 8'h00_F4);
		rd_chk(8'h00_D1, 8'h00_04);
		`CHK("thermal", 1'b1, o_ana.thermal_on)
		`CHK("bias", 1'b1, o_ana.bias_on)
		`CHK("valid", 1'b1, valid)
		wr(8'h00_D1, 8'h00_09);
		`CHK("ref", 2'b11, {o_ana.ref_buffer_on, o_ana.ref_from_supply})
		`CHK("bias", 1'b0, o_ana.bias_on)
		`CHK("pin", 1'b1, vpin)
		wr(8'h00_D1, 8'h00_02);
		`CHK("bias", 1'b1, o_ana.bias_on)
		`CHK("ref", 2'b00, {o_ana.ref_buffer_on, o_ana.ref_from_supply})
		wr(8'h00_D1, 8'h00_00);
		req(1'b1, 1'b0, 1'b1);
		req(1'b0, 1'b1, 1'b1);
		req(1'b0, 1'b0, 1'b0);
		// Reset in mid-run must bring both registers back
		wr(8'h00_D1, 8'h00_0F);
		wr(8'h00_BB, 8'h00_05);
		i_rstn = 1'b0;
		repeat (2) @(negedge i_sys_clk);
		i_rstn = 1'b1;
		`CHK("src", aisel_pkg::AISEL_SRC_GROUND, o_ana.src)
		`CHK("ref", 2'b00, {o_ana.ref_buffer_on, o_ana.ref_from_supply})
		rd_chk(8'h00_BB, 8'h00_3F);
		rd_chk(8'h00_D1, 8'h00_00);
		give_verdict();
	end
endmodule // tb_top
